/* design/bpt_cmp_if.sv */
// Interface: one threshold comparator channel
interface bpt_cmp_if;
  logic [6:0] code;   // Threshold code
  logic off;          // Disable bit
  logic [15:0] level; // Measured value
  logic above;        // Measured value above threshold and enabled

  // ==========================================================
  // Comparator side and register side
  modport cmp (input code, input off, input level, output above);
  modport regs (output code, output off, output level, input above);
endinterface

/* design/bpt_pkg.sv */
// Package: offsets, reset values and threshold scaling for the battery threshold registers
package bpt_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] BPT_OFS_VOLT_ALARM = 8'h01; // Battery voltage alarm level
  localparam logic [7:0] BPT_OFS_CURR_LIMIT = 8'h02; // Battery current limit level
  localparam logic [7:0] BPT_OFS_CURR_ALARM = 8'h03; // Battery current alarm level

  // ==========================================================
  // Reset values
  localparam logic [7:0] BPT_RST_VOLT_ALARM = 8'h1C; // Code 011100, 3500 mV plus 28 steps
  localparam logic [7:0] BPT_RST_CURR_LIMIT = 8'h3D; // Code 0111101, 8.1 A
  localparam logic [7:0] BPT_RST_CURR_ALARM = 8'h3C; // Code 0111100

  // ==========================================================
  // Field positions
  localparam int BPT_OFF_BIT = 7;        // Disable bit in every register
  localparam int BPT_VCODE_MSB = 5;      // Voltage code is bits 5..0
  localparam int BPT_ICODE_MSB = 6;      // Current codes are bits 6..0
  localparam logic [7:0] BPT_VOLT_WMASK = 8'hBF; // Bit 6 reserved, reads zero

  // ==========================================================
  // Threshold scaling, voltage in mV and current in mA
  localparam logic [15:0] BPT_VOLT_BASE_MV = 16'h0DAC; // 3500 mV
  localparam logic [15:0] BPT_VOLT_STEP_MV = 16'h0019; // 25 mV
  localparam logic [15:0] BPT_VOLT_MAX_MV = 16'hFFFF;  // No clamp on voltage
  localparam logic [15:0] BPT_CURR_BASE_MA = 16'h07D0; // 2000 mA
  localparam logic [15:0] BPT_CURR_STEP_MA = 16'h0064; // 100 mA
  localparam logic [15:0] BPT_CURR_MAX_MA = 16'h2710;  // 10000 mA clamp

  // ==========================================================
  // Comparator channel indices
  localparam int BPT_CH_VALARM = 0; // Voltage alarm
  localparam int BPT_CH_ILIMIT = 1; // Current limit
  localparam int BPT_CH_IALARM = 2; // Current alarm
  localparam int BPT_NUM_CH = 3;    // Channel count

  // ==========================================================
  // Serial slave states
  typedef enum logic [3:0] {
    BPT_ST_IDLE,
    BPT_ST_ADDR,
    BPT_ST_AACK,
    BPT_ST_PTR,
    BPT_ST_PACK,
    BPT_ST_WR,
    BPT_ST_WACK,
    BPT_ST_RD,
    BPT_ST_RACK
  } bpt_state_t;

endpackage

/* design/bpt_threshold_cmp.sv */
// Comparator: decodes a threshold code and compares a measured value
module bpt_threshold_cmp
  import bpt_pkg::*;
#(
  parameter logic [15:0] BASE = 16'h0000, // Threshold at code zero
  parameter logic [15:0] STEP = 16'h0001, // Weight of one code step
  parameter logic [15:0] MAX = 16'hFFFF   // Saturation value
) (
  bpt_cmp_if.cmp ch // Comparator channel
);

  logic [15:0] full; // Unclamped threshold
  logic [15:0] thr;  // Effective threshold

  // ==========================================================
  // Decode and compare
  always_comb begin
    full = BASE + 16'(ch.code) * STEP;
    thr = (full > MAX) ? MAX : full;
    ch.above = !ch.off && (ch.level > thr);
  end

endmodule

/* design/bpt_threshold_regs.sv */
// Battery threshold register bank with serial slave and alarm comparators
// How it works
// - register-reset command restores all; watchdog ignored
// - voltage alarm is 3.5 V plus 25 mV steps
// - voltage alarm register resets to 0x1C
// - voltage above alarm level raises interrupt
// - current limit is 2 A plus 100 mA steps
// - current limit saturates at 10 A
// - current limit register resets to 0x3D
// - current above limit disables the output
// - current alarm uses same 2 A, 100 mA scale
// - current alarm register resets to 0x3C
// - current above alarm level raises interrupt
module bpt_threshold_regs
  import bpt_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h65 // Slave address, value arbitrary
) (
  input wire logic ref_clk,               // Clock, 250 MHz
  input wire logic rst,                   // Async reset, active high
  input wire logic ce,                    // Clock enable, freezes all state when low
  input wire logic scl_in,                // Serial clock from host
  input wire logic sda_in,                // Serial data level on the wire
  output logic sda_out,                   // Serial data drive value, always low
  output logic sda_oe,                    // Serial data pull-down enable
  input wire logic reg_reset_cmd,         // Register-reset command pulse
  input wire logic [15:0] batt_voltage_mv, // Measured battery voltage, mV
  input wire logic [15:0] batt_current_ma, // Measured battery current, mA
  output logic batt_voltage_alarm,        // Voltage alarm level
  output logic batt_current_alarm,        // Current alarm level
  output logic output_disable,            // Overcurrent protection: output off
  output logic alarm_int                  // One-cycle pulse on a new alarm
);

  // ==========================================================
  // Registers and serial slave state
  logic [7:0] volt_alarm_reg; // Battery voltage alarm level
  logic [7:0] curr_limit_reg; // Battery current limit level
  logic [7:0] curr_alarm_reg; // Battery current alarm level
  bpt_state_t state;          // Serial slave state
  logic scl_q;                // Previous serial clock sample
  logic sda_q;                // Previous serial data sample
  logic [3:0] bit_cnt;        // Bits moved in current byte
  logic [7:0] shift_in;       // Received byte
  logic [7:0] tx_byte;        // Byte being sent
  logic [7:0] ptr;            // Register pointer
  logic rnw;                  // Transfer direction, high for read
  logic wr_en;                // Register write strobe
  logic [7:0] wr_data;        // Register write data
  logic [7:0] rd_data;        // Read mux output
  logic scl_rise;             // Serial clock rising
  logic scl_fall;             // Serial clock falling
  logic bus_start;            // Start condition
  logic bus_stop;             // Stop condition
  logic [BPT_NUM_CH-1:0] above; // Comparator results

  // Edge and condition detection
  assign scl_rise = scl_in && !scl_q;
  assign scl_fall = !scl_in && scl_q;
  assign bus_start = scl_in && scl_q && sda_q && !sda_in;
  assign bus_stop = scl_in && scl_q && !sda_q && sda_in;

  // ==========================================================
  // Read mux, unmapped offsets read zero
  always_comb begin
    if (ptr == BPT_OFS_VOLT_ALARM) begin
      rd_data = volt_alarm_reg;
    end else if (ptr == BPT_OFS_CURR_LIMIT) begin
      rd_data = curr_limit_reg;
    end else if (ptr == BPT_OFS_CURR_ALARM) begin
      rd_data = curr_alarm_reg;
    end else begin
      rd_data = 8'h00;
    end
  end

  // ==========================================================
  // Line sampling
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce) begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // ==========================================================
  // Serial slave sequencer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= BPT_ST_IDLE;
      bit_cnt <= 4'h0;
      shift_in <= 8'h00;
      tx_byte <= 8'h00;
      ptr <= 8'h00;
      rnw <= 1'b0;
      sda_oe <= 1'b0;
      wr_en <= 1'b0;
      wr_data <= 8'h00;
    end else if (ce) begin
      wr_en <= 1'b0;
      if (bus_start) begin
        // Start or repeated start: expect address
        state <= BPT_ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (bus_stop) begin
        // Stop: release and go idle
        state <= BPT_ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          BPT_ST_ADDR, BPT_ST_PTR, BPT_ST_WR: begin
            // Receive a byte, then acknowledge on the falling edge
            if (scl_rise) begin
              shift_in <= {shift_in[6:0], sda_in};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              if (state == BPT_ST_ADDR) begin
                if (shift_in[7:1] == DEV_ADDR) begin
                  sda_oe <= 1'b1;
                  rnw <= shift_in[0];
                  state <= BPT_ST_AACK;
                end else begin
                  state <= BPT_ST_IDLE;
                end
              end else if (state == BPT_ST_PTR) begin
                sda_oe <= 1'b1;
                ptr <= shift_in;
                state <= BPT_ST_PACK;
              end else begin
                sda_oe <= 1'b1;
                wr_en <= 1'b1;
                wr_data <= shift_in;
                state <= BPT_ST_WACK;
              end
            end
          end
          BPT_ST_AACK: begin
            // Address acknowledged: read starts sending, write takes pointer
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (rnw) begin
                tx_byte <= rd_data;
                sda_oe <= !rd_data[7];
                state <= BPT_ST_RD;
              end else begin
                sda_oe <= 1'b0;
                state <= BPT_ST_PTR;
              end
            end
          end
          BPT_ST_PACK: begin
            // Pointer acknowledged
            if (scl_fall) begin
              sda_oe <= 1'b0;
              bit_cnt <= 4'h0;
              state <= BPT_ST_WR;
            end
          end
          BPT_ST_WACK: begin
            // Data acknowledged, pointer advances
            if (scl_fall) begin
              sda_oe <= 1'b0;
              bit_cnt <= 4'h0;
              ptr <= ptr + 8'h01;
              state <= BPT_ST_WR;
            end
          end
          BPT_ST_RD: begin
            // Send a byte, most significant bit first
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == 4'h8) begin
                sda_oe <= 1'b0;
                state <= BPT_ST_RACK;
              end else begin
                tx_byte <= {tx_byte[6:0], 1'b0};
                sda_oe <= !tx_byte[6];
              end
            end
          end
          BPT_ST_RACK: begin
            // Host ack continues the read, nack ends it
            if (scl_rise) begin
              if (sda_in) begin
                state <= BPT_ST_IDLE;
              end else begin
                ptr <= ptr + 8'h01;
              end
            end else if (scl_fall) begin
              bit_cnt <= 4'h0;
              tx_byte <= rd_data;
              sda_oe <= !rd_data[7];
              state <= BPT_ST_RD;
            end
          end
          default: begin
            // Idle: wait for a start
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Threshold registers; reset command wins over a write
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      volt_alarm_reg <= BPT_RST_VOLT_ALARM;
      curr_limit_reg <= BPT_RST_CURR_LIMIT;
      curr_alarm_reg <= BPT_RST_CURR_ALARM;
    end else if (ce) begin
      if (reg_reset_cmd) begin
        // No watchdog input reaches these registers
        volt_alarm_reg <= BPT_RST_VOLT_ALARM;
        curr_limit_reg <= BPT_RST_CURR_LIMIT;
        curr_alarm_reg <= BPT_RST_CURR_ALARM;
      end else if (wr_en) begin
        if (ptr == BPT_OFS_VOLT_ALARM) begin
          volt_alarm_reg <= wr_data & BPT_VOLT_WMASK;
        end else if (ptr == BPT_OFS_CURR_LIMIT) begin
          curr_limit_reg <= wr_data;
        end else if (ptr == BPT_OFS_CURR_ALARM) begin
          curr_alarm_reg <= wr_data;
        end
      end
    end
  end

  // ==========================================================
  // Comparator channels
  bpt_cmp_if ch_if[BPT_NUM_CH] ();

  assign ch_if[BPT_CH_VALARM].code = {1'b0, volt_alarm_reg[BPT_VCODE_MSB:0]};
  assign ch_if[BPT_CH_VALARM].off = volt_alarm_reg[BPT_OFF_BIT];
  assign ch_if[BPT_CH_VALARM].level = batt_voltage_mv;
  assign ch_if[BPT_CH_ILIMIT].code = curr_limit_reg[BPT_ICODE_MSB:0];
  assign ch_if[BPT_CH_ILIMIT].off = curr_limit_reg[BPT_OFF_BIT];
  assign ch_if[BPT_CH_ILIMIT].level = batt_current_ma;
  assign ch_if[BPT_CH_IALARM].code = curr_alarm_reg[BPT_ICODE_MSB:0];
  assign ch_if[BPT_CH_IALARM].off = curr_alarm_reg[BPT_OFF_BIT];
  assign ch_if[BPT_CH_IALARM].level = batt_current_ma;

  // One comparator per channel, scale chosen by channel
  for (genvar i = 0; i < BPT_NUM_CH; i++) begin : g_cmp
    bpt_threshold_cmp #(
      .BASE((i == BPT_CH_VALARM) ? BPT_VOLT_BASE_MV : BPT_CURR_BASE_MA),
      .STEP((i == BPT_CH_VALARM) ? BPT_VOLT_STEP_MV : BPT_CURR_STEP_MA),
      .MAX((i == BPT_CH_VALARM) ? BPT_VOLT_MAX_MV : BPT_CURR_MAX_MA)
    ) u_cmp (
      .ch(ch_if[i])
    );
    assign above[i] = ch_if[i].above;
  end

  // ==========================================================
  // Alarm, protection and interrupt outputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      batt_voltage_alarm <= 1'b0;
      batt_current_alarm <= 1'b0;
      output_disable <= 1'b0;
      alarm_int <= 1'b0;
      sda_out <= 1'b0;
    end else if (ce) begin
      batt_voltage_alarm <= above[BPT_CH_VALARM];
      batt_current_alarm <= above[BPT_CH_IALARM];
      output_disable <= above[BPT_CH_ILIMIT];
      // New alarm crossing raises a pulse toward the host
      alarm_int <= (above[BPT_CH_VALARM] && !batt_voltage_alarm)
        || (above[BPT_CH_IALARM] && !batt_current_alarm);
      sda_out <= 1'b0;
    end
  end

endmodule

/* testbench/battery_protection_threshold_regs_bench.sv */
// Testbench: serial register access, thresholds and reset command
module battery_protection_threshold_regs_bench;
  import bpt_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] ADDR = 7'h65; // Slave address, value arbitrary
  logic ref_clk, rst, ce, scl_in, sda_in, sda_out, sda_oe, reg_reset_cmd, host_pull, got_stb;
  logic [15:0] batt_voltage_mv, batt_current_ma;
  logic batt_voltage_alarm, batt_current_alarm, output_disable, alarm_int;
  logic [7:0] got;
  logic [7:0] exp_q[$];
  int errors = 0;
  int cmp_count = 0;
  // Open-drain wire with pull-up; device pulls only while enabled and driving low
  assign sda_in = !((sda_oe && !sda_out) || host_pull);
  bpt_threshold_regs #(.DEV_ADDR(ADDR)) u_dut (.ref_clk, .rst, .ce, .scl_in, .sda_in, .sda_out,
    .sda_oe, .reg_reset_cmd, .batt_voltage_mv, .batt_current_ma, .batt_voltage_alarm,
    .batt_current_alarm, .output_disable, .alarm_int);
  bpt_host_model u_host (.ref_clk, .sda(sda_in), .scl(scl_in), .pull(host_pull));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Verdict and end of run
  task automatic report_and_stop();
    if (errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t output %b, expected %b", $time, g, e);
    end
  endtask
  // Byte with device acknowledge
  task automatic send(input logic [7:0] d);
    logic [7:0] q;
    logic s;
    u_host.xfer(d, q, s);
    chk(s, 1'b0);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    u_host.start();
    send({ADDR, 1'b0});
    send(p);
    send(d);
    u_host.stop();
  endtask
  // Pointer write, repeated start, one byte read with NACK
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] q;
    logic s;
    exp_q.push_back(e);
    u_host.start();
    send({ADDR, 1'b0});
    send(p);
    u_host.start();
    send({ADDR, 1'b1});
    u_host.xfer(8'hFF, q, s);
    got <= q;
    got_stb <= 1'b1;
    @(posedge ref_clk);
    got_stb <= 1'b0;
    u_host.stop();
  endtask
  // Apply levels; e = voltage alarm, current alarm, output off, interrupt
  task automatic lvl(input logic [15:0] v, input logic [15:0] i, input logic [3:0] e);
    @(posedge ref_clk);
    batt_voltage_mv <= v;
    batt_current_ma <= i;
    @(posedge ref_clk);
    #1;
    chk(alarm_int, e[0]);
    chk(batt_voltage_alarm, e[3]);
    chk(batt_current_alarm, e[2]);
    chk(output_disable, e[1]);
  endtask
  // Current threshold in mA, held at 10 A
  function automatic logic [15:0] th(input logic [6:0] k);
    int t;
    t = 2000 + 100 * k;
    return (t > 10000) ? 16'h2710 : 16'(t);
  endfunction
  // Read results against the oldest note
  always @(posedge ref_clk) begin
    if (got_stb === 1'b1) begin
      cmp_count++;
      if (got !== exp_q.pop_front()) begin
        errors++;
        $display("[ERR] %0t read data %h wrong", $time, got);
      end
    end
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    errors++;
    $display("[ERR] %0t run hung", $time);
    report_and_stop();
  end
  initial begin
    logic [5:0] c;
    logic [6:0] k, a;
    logic [15:0] tv, tl, ta;
    rst = 1'b1;
    ce = 1'b1;
    reg_reset_cmd = 1'b0;
    batt_voltage_mv = 16'h0000;
    batt_current_ma = 16'h0000;
    got = 8'h00;
    got_stb = 1'b0;
    void'($urandom(68));
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rd(8'h01, 8'h1C);
    rd(8'h02, 8'h3D);
    rd(8'h03, 8'h3C);
    rd(8'h00, 8'h00);
    // Default voltage code 28: 3500 mV plus 28 steps of 25 mV
    lvl(16'h1068, 16'h1F40, 4'h0);
    lvl(16'h1069, 16'h1F41, 4'hD);
    lvl(16'h1069, 16'h1FA5, 4'hE);
    lvl(16'h0000, 16'h0000, 4'h0);
    for (int n = 0; n < 4; n++) begin
      c = 6'($urandom);
      k = (n == 0) ? 7'h7F : 7'($urandom);
      a = k >> 1;
      tv = 16'(3500 + 25 * c);
      tl = th(k);
      ta = th(a);
      wr(8'h01, {2'b00, c});
      wr(8'h02, {1'b0, k});
      wr(8'h03, {1'b0, a});
      rd(8'h02, {1'b0, k});
      lvl(tv, 16'h0000, 4'h0);
      lvl(tv + 16'h0001, 16'h0000, 4'h9);
      lvl(16'h0000, ta, 4'h0);
      lvl(16'h0000, ta + 16'h0001, {2'b01, ta >= tl, 1'b1});
      lvl(16'h0000, tl, {1'b0, tl > ta, 2'b00});
      lvl(16'h0000, tl + 16'h0001, {3'b011, ta == tl});
      lvl(16'h0000, 16'h0000, 4'h0);
    end
    wr(8'h01, 8'hFF);
    rd(8'h01, 8'hBF);
    wr(8'h02, 8'h80);
    wr(8'h03, 8'h80);
    ce <= 1'b0;
    repeat (3) @(posedge ref_clk);
    ce <= 1'b1;
    lvl(16'hFFFF, 16'hFFFF, 4'h0);
    lvl(16'h1069, 16'h1FA5, 4'h0);
    @(posedge ref_clk);
    reg_reset_cmd <= 1'b1;
    @(posedge ref_clk);
    reg_reset_cmd <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(batt_voltage_alarm, 1'b1);
    chk(output_disable, 1'b1);
    chk(batt_current_alarm, 1'b1);
    rd(8'h01, 8'h1C);
    rd(8'h03, 8'h3C);
    report_and_stop();
  end
endmodule

/* testbench/bpt_host_model.sv */
// Serial host model: drives the clock and pulls the data wire low
module bpt_host_model (
  input wire logic ref_clk, // Clock
  input wire logic sda, // Resolved data wire
  output logic scl, // Serial clock
  output logic pull // High pulls data low
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // Wait some edges
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // One bit slot, data moved only mid low phase
  task automatic bit_io(input logic b, output logic s);
    wt(2);
    pull <= !b;
    wt(2);
    scl <= 1'b1;
    wt(2);
    s = sda;
    wt(2);
    scl <= 1'b0;
  endtask
  // Start or repeated start: data falls while clock high
  task automatic start();
    wt(2);
    pull <= 1'b0;
    wt(2);
    scl <= 1'b1;
    wt(4);
    pull <= 1'b1;
    wt(4);
    scl <= 1'b0;
  endtask
  // Stop: data rises while clock high
  task automatic stop();
    wt(2);
    pull <= 1'b1;
    wt(2);
    scl <= 1'b1;
    wt(4);
    pull <= 1'b0;
    wt(4);
  endtask
  // Byte MSB first, then a released acknowledge slot
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic s);
    for (int n = 7; n >= 0; n--) begin
      bit_io(d[n], q[n]);
    end
    bit_io(1'b1, s);
  endtask
endmodule

/* testbench/bpt_threshold_regs_chk.sv */
// Checker: port-level properties of the threshold register bank
module bpt_threshold_regs_chk
  import bpt_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic rst, // Reset
  input wire logic ce, // Clock enable
  input wire logic scl_in, // Serial clock
  input wire logic sda_in, // Data wire
  input wire logic sda_out, // Data drive value
  input wire logic sda_oe, // Data pull enable
  input wire logic reg_reset_cmd, // Register reset
  input wire logic [15:0] batt_voltage_mv, // Voltage
  input wire logic [15:0] batt_current_ma, // Current
  input wire logic batt_voltage_alarm, // Voltage alarm
  input wire logic batt_current_alarm, // Current alarm
  input wire logic output_disable, // Output off
  input wire logic alarm_int // Interrupt pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // ==========================================================
  // Interrupt pulses
  a_int_on_rise: assert property (
    $rose(batt_voltage_alarm) || $rose(batt_current_alarm) |-> alarm_int)
    else $error("no interrupt on alarm rise");
  a_int_only_rise: assert property (
    alarm_int && $past(ce) |-> $rose(batt_voltage_alarm) || $rose(batt_current_alarm))
    else $error("interrupt without alarm rise");
  // ==========================================================
  // Threshold floors: code zero is the lowest level
  a_volt_floor: assert property (
    ce && batt_voltage_mv <= BPT_VOLT_BASE_MV |=> !batt_voltage_alarm)
    else $error("voltage alarm at or below base");
  a_limit_floor: assert property (
    ce && batt_current_ma <= BPT_CURR_BASE_MA |=> !output_disable)
    else $error("output off at or below base");
  a_calarm_floor: assert property (
    ce && batt_current_ma <= BPT_CURR_BASE_MA |=> !batt_current_alarm)
    else $error("current alarm at or below base");
  // ==========================================================
  // Reset command restores default levels; outputs follow the level one edge late
  a_limit_default: assert property (
    reg_reset_cmd ##1 (ce && !reg_reset_cmd && $stable(batt_current_ma))[*2]
    |=> output_disable == ($past(batt_current_ma) > 16'h1FA4))
    else $error("limit not 8.1 A after reset command");
  // Code 28 gives 3500 mV plus 28 steps of 25 mV
  a_valarm_default: assert property (
    reg_reset_cmd ##1 (ce && !reg_reset_cmd && $stable(batt_voltage_mv))[*2]
    |=> batt_voltage_alarm == ($past(batt_voltage_mv) > 16'h1068))
    else $error("voltage alarm level wrong after reset command");
  a_calarm_default: assert property (
    reg_reset_cmd ##1 (ce && !reg_reset_cmd && $stable(batt_current_ma))[*2]
    |=> batt_current_alarm == ($past(batt_current_ma) > 16'h1F40))
    else $error("current alarm not 8 A after reset command");
  // ==========================================================
  // Data pull only begins while the serial clock is low
  a_pull_scl_low: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("data pulled while clock high");
  c_int: cover property (alarm_int);
  c_off: cover property ($rose(output_disable));
  c_pull: cover property ($rose(sda_oe));
endmodule
bind bpt_threshold_regs bpt_threshold_regs_chk u_chk (.ref_clk, .rst, .ce, .scl_in, .sda_in,
  .sda_out, .sda_oe, .reg_reset_cmd, .batt_voltage_mv, .batt_current_ma, .batt_voltage_alarm,
  .batt_current_alarm, .output_disable, .alarm_int);
